// >>> rtl/dmtr_pkg.sv
// dmtr_pkg: constants, types and register map for the data-memory and table-read block.
// assumes a single system clock; every clock cycle is one instruction cycle.
`default_nettype none
package dmtr_pkg;
    // ======================================================
    // special register offsets
    localparam logic [7:0] ADDR_WINDOW_ZERO = 8'h00;
    localparam logic [7:0] ADDR_POINTER_ZERO = 8'h01;
    localparam logic [7:0] ADDR_WINDOW_ONE = 8'h02;
    localparam logic [7:0] ADDR_POINTER_ONE = 8'h03;
    localparam logic [7:0] ADDR_BANK_SELECT = 8'h04;
    localparam logic [7:0] ADDR_PROGRAM_COUNTER_LOW = 8'h06;
    localparam logic [7:0] ADDR_TABLE_INDEX = 8'h07;
    localparam logic [7:0] ADDR_TABLE_UPPER_BYTE = 8'h08;
    // ======================================================
    // data memory layout
    localparam logic [7:0] GP_START = 8'h40;
    localparam logic [7:0] BANK1_LAST = 8'h5b;
    localparam logic [7:0] BANK23_LAST = 8'h7f;
    localparam logic [8:0] BANK1_BASE = 9'h0c0;
    localparam logic [8:0] BANK2_BASE = 9'h0dc;
    localparam logic [8:0] BANK3_BASE = 9'h11c;
    localparam int GP_TOTAL = 348;
    localparam int BANK0_SIZE = 192;
    // ======================================================
    // fields and reset values
    localparam logic [7:0] BANK_SELECT_MASK = 8'h23;
    localparam int DM_BANK_LSB = 0;
    localparam int DM_BANK_W = 2;
    localparam logic [5:0] LAST_PAGE_UPPER = 6'h3f;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [13:0] RESET_PM_ADDR = 14'h0000;
    localparam int TABLE_CYCLES = 2;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b01,
        ST_FETCH = 2'b10
    } dmtr_state_e;

    // one data-memory operation from the execution unit
    typedef struct packed {
        logic rd;
        logic wr;
        logic bit_set;
        logic bit_clr;
        logic [2:0] bit_sel;
        logic [7:0] addr;
        logic [7:0] wdata;
    } dmtr_req_s;

    // one table read instruction
    typedef struct packed {
        logic go;
        logic last_page;
        logic [7:0] dest;
    } dmtr_tbl_s;
endpackage
`default_nettype wire

// >>> rtl/dmtr_top.sv
// dmtr_top: banked data memory, indirect windows and table-read engine.
// assumes the execution unit issues one operation per cycle and the program
// memory answers pm_data combinationally in the cycle pm_rd is high.
// Notes on behaviour
// - current page: upper counter bits plus index
// - last page: upper six address bits ones
// - table read loads upper byte automatically
// - upper byte register ignores software writes
// - table instructions take two cycles
// - data memory has four byte-wide banks
// - bank zero: registers low, RAM high
// - bank one: 28 bytes for display
// - banks two, three: 64 bytes each
// - direct addressing reaches bank zero only
// - single bit set and clear supported
// - unused register locations read zero
// - registers visible in every bank
// - window access acts on pointed location
// - window zero bank zero; one any bank
// - window through window: read zero, write ignored
// - low byte to destination, unused bits zero
// - bank select low bits steer indirect bank
`default_nettype none
module dmtr_top
    import dmtr_pkg::*;
(
    input wire logic clock,
    input wire logic rst,
    input wire dmtr_req_s req,
    input wire dmtr_tbl_s tbl,
    input wire logic [5:0] program_counter_upper_bits,
    input wire logic [7:0] pc_low,
    input wire logic [15:0] pm_data,
    output logic [7:0] rdata,
    output logic busy,
    output logic tbl_done,
    output logic pcl_load,
    output logic [7:0] pcl_value,
    output logic [13:0] pm_addr,
    output logic pm_rd
);
    // ======================================================
    // state
    dmtr_state_e state, next_state;
    logic [7:0] pointer_zero, next_pointer_zero;
    logic [7:0] pointer_one, next_pointer_one;
    logic [7:0] bank_select, next_bank_select;
    logic [7:0] table_index, next_table_index;
    logic [7:0] table_upper_byte, next_table_upper_byte;
    logic [7:0] dest, next_dest;
    logic [7:0] next_rdata;
    logic next_pcl_load;
    logic [7:0] next_pcl_value;
    logic [13:0] next_pm_addr;
    logic [7:0] mem [GP_TOTAL];
    logic [7:0] next_mem [GP_TOTAL];

    // ======================================================
    // address resolution
    logic fetching;
    logic [7:0] res_addr;
    logic [1:0] eff_bank;
    logic [7:0] eff_off;
    logic indirect;
    logic self_ref;
    logic gp_hit;
    logic [8:0] gp_idx;
    logic [7:0] cur_val;
    logic cpu_ok;
    logic tbl_ok;
    logic do_write;
    logic [7:0] wval;

    assign fetching = (state == ST_FETCH);
    assign busy = fetching;
    assign tbl_done = fetching;
    assign pm_rd = fetching;
    assign cpu_ok = !fetching;
    assign tbl_ok = tbl.go && !fetching;
    // the table load uses the port in its second cycle, so the cpu waits
    assign res_addr = fetching ? dest : req.addr;

    always_comb
    begin
        eff_bank = 2'b00;
        eff_off = res_addr;
        indirect = 1'b0;
        if (res_addr == ADDR_WINDOW_ZERO)
        begin
            eff_off = pointer_zero;
            indirect = 1'b1;
        end
        else if (res_addr == ADDR_WINDOW_ONE)
        begin
            eff_off = pointer_one;
            eff_bank = bank_select[DM_BANK_LSB +: DM_BANK_W];
            indirect = 1'b1;
        end
    end

    assign self_ref = indirect &&
        (eff_off == ADDR_WINDOW_ZERO || eff_off == ADDR_WINDOW_ONE);

    always_comb
    begin
        gp_hit = 1'b0;
        gp_idx = 9'(eff_off - GP_START);
        if (eff_off >= GP_START)
        begin
            unique case (eff_bank)
                2'd0: gp_hit = 1'b1;
                2'd1:
                begin
                    gp_hit = (eff_off <= BANK1_LAST);
                    gp_idx = 9'(eff_off - GP_START) + BANK1_BASE;
                end
                2'd2:
                begin
                    gp_hit = (eff_off <= BANK23_LAST);
                    gp_idx = 9'(eff_off - GP_START) + BANK2_BASE;
                end
                2'd3:
                begin
                    gp_hit = (eff_off <= BANK23_LAST);
                    gp_idx = 9'(eff_off - GP_START) + BANK3_BASE;
                end
            endcase
        end
    end

    // registers sit below the RAM whatever bank is chosen
    always_comb
    begin
        cur_val = RESET_BYTE;
        if (self_ref)
        begin
            cur_val = RESET_BYTE;
        end
        else if (eff_off < GP_START)
        begin
            unique case (eff_off)
                ADDR_POINTER_ZERO: cur_val = pointer_zero;
                ADDR_POINTER_ONE: cur_val = pointer_one;
                ADDR_BANK_SELECT: cur_val = bank_select;
                ADDR_PROGRAM_COUNTER_LOW: cur_val = pc_low;
                ADDR_TABLE_INDEX: cur_val = table_index;
                ADDR_TABLE_UPPER_BYTE: cur_val = table_upper_byte;
                default: cur_val = RESET_BYTE;
            endcase
        end
        else if (gp_hit)
        begin
            cur_val = mem[gp_idx];
        end
    end

    // bit operations are read-modify-write of the resolved location
    always_comb
    begin
        wval = cur_val;
        if (fetching)
        begin
            wval = pm_data[7:0];
        end
        else if (req.wr)
        begin
            wval = req.wdata;
        end
        else if (req.bit_set)
        begin
            wval[req.bit_sel] = 1'b1;
        end
        else if (req.bit_clr)
        begin
            wval[req.bit_sel] = 1'b0;
        end
    end

    assign do_write = !self_ref &&
        (fetching || req.wr || req.bit_set || req.bit_clr);

    // ======================================================
    // next values
    always_comb
    begin
        next_state = state;
        next_pointer_zero = pointer_zero;
        next_pointer_one = pointer_one;
        next_bank_select = bank_select;
        next_table_index = table_index;
        next_table_upper_byte = table_upper_byte;
        next_dest = dest;
        next_rdata = rdata;
        next_pcl_load = 1'b0;
        next_pcl_value = pcl_value;
        next_pm_addr = pm_addr;
        next_mem = mem;
        if (cpu_ok && req.rd)
        begin
            next_rdata = cur_val;
        end
        if (do_write)
        begin
            if (eff_off < GP_START)
            begin
                unique case (eff_off)
                    ADDR_POINTER_ZERO: next_pointer_zero = wval;
                    ADDR_POINTER_ONE: next_pointer_one = wval;
                    ADDR_BANK_SELECT: next_bank_select = wval & BANK_SELECT_MASK;
                    ADDR_PROGRAM_COUNTER_LOW:
                    begin
                        next_pcl_load = 1'b1;
                        next_pcl_value = wval;
                    end
                    ADDR_TABLE_INDEX: next_table_index = wval;
                    default: next_pcl_load = 1'b0;
                endcase
            end
            else if (gp_hit)
            begin
                next_mem[gp_idx] = wval;
            end
        end
        unique case (state)
            ST_IDLE:
            begin
                if (tbl_ok)
                begin
                    next_state = ST_FETCH;
                    next_dest = tbl.dest;
                    if (tbl.last_page)
                    begin
                        next_pm_addr = {LAST_PAGE_UPPER, table_index};
                    end
                    else
                    begin
                        next_pm_addr = {program_counter_upper_bits, table_index};
                    end
                end
            end
            ST_FETCH:
            begin
                next_table_upper_byte = pm_data[15:8];
                next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    // ======================================================
    // registers; RAM keeps no reset value, like the real array
    always_ff @(posedge clock)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            pointer_zero <= RESET_BYTE;
            pointer_one <= RESET_BYTE;
            bank_select <= RESET_BYTE;
            table_index <= RESET_BYTE;
            table_upper_byte <= RESET_BYTE;
            dest <= RESET_BYTE;
            rdata <= RESET_BYTE;
            pcl_load <= 1'b0;
            pcl_value <= RESET_BYTE;
            pm_addr <= RESET_PM_ADDR;
        end
        else
        begin
            state <= next_state;
            pointer_zero <= next_pointer_zero;
            pointer_one <= next_pointer_one;
            bank_select <= next_bank_select;
            table_index <= next_table_index;
            table_upper_byte <= next_table_upper_byte;
            dest <= next_dest;
            rdata <= next_rdata;
            pcl_load <= next_pcl_load;
            pcl_value <= next_pcl_value;
            pm_addr <= next_pm_addr;
        end
        mem <= next_mem;
    end

    // ======================================================
    // assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (rst);

    AST_CUR_PAGE: assert property (
        tbl_ok && !tbl.last_page |=>
        pm_addr == {$past(program_counter_upper_bits), $past(table_index)})
        else $error("current page address wrong");
    AST_LAST_PAGE: assert property (
        tbl_ok && tbl.last_page |=> pm_addr[13:8] == LAST_PAGE_UPPER && pm_rd)
        else $error("last page address wrong");
    AST_UPPER_LOAD: assert property (
        fetching |=> table_upper_byte == $past(pm_data[15:8]))
        else $error("upper byte not loaded");
    AST_UPPER_RO: assert property (
        !fetching && req.wr && req.addr == ADDR_TABLE_UPPER_BYTE
        |=> $stable(table_upper_byte))
        else $error("upper byte was written");
    AST_TWO_CYCLES: assert property (
        tbl_ok |=> tbl_done ##1 !busy)
        else $error("table read not two cycles");
    AST_DIRECT_BANK0: assert property (
        cpu_ok && req.wr && req.addr >= GP_START
        |=> mem[$past(req.addr) - GP_START] == $past(req.wdata))
        else $error("direct access left bank zero");
    AST_BIT_SET: assert property (
        cpu_ok && !req.wr && req.bit_set && gp_hit && !self_ref
        |=> mem[$past(gp_idx)][$past(req.bit_sel)])
        else $error("bit not set");
    AST_UNUSED_ZERO: assert property (
        cpu_ok && req.rd && req.addr > ADDR_TABLE_UPPER_BYTE && req.addr < GP_START
        |=> rdata == RESET_BYTE)
        else $error("unused register not zero");
    AST_WINDOW_WRITE: assert property (
        cpu_ok && req.wr && indirect && gp_hit && !self_ref
        |=> mem[$past(gp_idx)] == $past(req.wdata))
        else $error("window write missed target");
    AST_WINDOW0_BANK: assert property (
        cpu_ok && req.wr && req.addr == ADDR_WINDOW_ZERO && pointer_zero >= GP_START
        |=> mem[$past(pointer_zero) - GP_START] == $past(req.wdata))
        else $error("window zero left bank zero");
    AST_SELF_ZERO: assert property (
        cpu_ok && req.rd && self_ref |=> rdata == RESET_BYTE)
        else $error("window through window not zero");

    COV_TABLE_LAST: cover property (tbl_ok && tbl.last_page ##2 !busy);
    COV_BANK3_WRITE: cover property (cpu_ok && req.wr && eff_bank == 2'd3 && gp_hit);
    COV_BIT_CLEAR: cover property (cpu_ok && req.bit_clr && gp_hit);
endmodule
`default_nettype wire

// >>> verif/dmtr_pm_model.sv
// dmtr_pm_model: program memory seen from the table-read fetch port.
// assumes pm_data is taken combinationally while pm_rd is high.
`default_nettype none
module dmtr_pm_model
    import dmtr_pkg::*;
(
    input wire logic clock,
    input wire logic [13:0] pm_addr,
    input wire logic pm_rd,
    output logic [15:0] pm_data
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [15:0] noise = 16'h0000;
    // ======================================================
    // word content
    // a released bus changes every cycle so a stale word never passes
    always @(posedge clock) noise <= noise + 16'h3c5b;
    assign pm_data = pm_rd ? {pm_addr[13:6], pm_addr[7:0] ^ 8'ha5} : noise;
endmodule
`default_nettype wire

// >>> verif/dmtr_top_bench.sv
// dmtr_top_bench: register table, then table reads and reset by hand.
// assumes one operation per cycle and a combinational program memory model.
`default_nettype none
module dmtr_top_bench
    import dmtr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [1:0] op;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic [7:0] exp;
    } dmtr_row_s;
    localparam logic [1:0] W = 2'h0;
    localparam logic [1:0] R = 2'h1;
    localparam logic [1:0] S = 2'h2;
    localparam logic [1:0] C = 2'h3;
    logic clock;
    logic rst;
    dmtr_req_s req;
    dmtr_tbl_s tbl;
    logic [5:0] pc_up;
    logic [7:0] pc_low;
    logic [15:0] pm_data;
    logic [7:0] rdata;
    logic busy;
    logic tbl_done;
    logic pcl_load;
    logic [7:0] pcl_value;
    logic [13:0] pm_addr;
    logic pm_rd;
    int mismatches = 0;
    int total_checks = 0;
    dmtr_row_s rows [$] = '{
        '{R, 8'h04, 8'h00, 8'h00}, '{R, 8'h08, 8'h00, 8'h00}, '{R, 8'h01, 8'h00, 8'h00},
        '{W, 8'h01, 8'h45, 8'h00}, '{W, 8'h45, 8'h3c, 8'h00}, '{R, 8'h00, 8'h00, 8'h3c},
        '{W, 8'h04, 8'hff, 8'h00}, '{R, 8'h04, 8'h00, 8'h23}, '{W, 8'h04, 8'h01, 8'h00},
        '{W, 8'h03, 8'h45, 8'h00}, '{W, 8'h02, 8'h77, 8'h00}, '{R, 8'h02, 8'h00, 8'h77},
        '{R, 8'h45, 8'h00, 8'h3c}, '{R, 8'h00, 8'h00, 8'h3c},
        '{W, 8'h03, 8'h5b, 8'h00}, '{W, 8'h02, 8'h12, 8'h00}, '{R, 8'h02, 8'h00, 8'h12},
        '{W, 8'h03, 8'h5c, 8'h00}, '{W, 8'h02, 8'h11, 8'h00}, '{R, 8'h02, 8'h00, 8'h00},
        '{W, 8'h04, 8'h02, 8'h00}, '{W, 8'h03, 8'h7f, 8'h00}, '{W, 8'h02, 8'h99, 8'h00},
        '{R, 8'h02, 8'h00, 8'h99}, '{W, 8'h03, 8'h80, 8'h00}, '{W, 8'h02, 8'h44, 8'h00},
        '{R, 8'h02, 8'h00, 8'h00}, '{W, 8'h04, 8'h03, 8'h00}, '{W, 8'h03, 8'h7f, 8'h00},
        '{W, 8'h02, 8'h66, 8'h00}, '{R, 8'h02, 8'h00, 8'h66}, '{W, 8'h04, 8'h02, 8'h00},
        '{R, 8'h02, 8'h00, 8'h99}, '{W, 8'h03, 8'h07, 8'h00}, '{W, 8'h02, 8'h5e, 8'h00},
        '{R, 8'h07, 8'h00, 8'h5e}, '{R, 8'h06, 8'h00, 8'h9c},
        '{W, 8'h03, 8'h00, 8'h00}, '{W, 8'h02, 8'h55, 8'h00}, '{R, 8'h02, 8'h00, 8'h00},
        '{R, 8'h01, 8'h00, 8'h45}, '{W, 8'h01, 8'h02, 8'h00}, '{R, 8'h00, 8'h00, 8'h00},
        '{W, 8'h09, 8'hff, 8'h00}, '{R, 8'h09, 8'h00, 8'h00}, '{R, 8'h05, 8'h00, 8'h00},
        '{W, 8'h50, 8'h00, 8'h00}, '{S, 8'h50, 8'h03, 8'h00}, '{R, 8'h50, 8'h00, 8'h08},
        '{W, 8'h50, 8'hff, 8'h00}, '{C, 8'h50, 8'h07, 8'h00}, '{R, 8'h50, 8'h00, 8'h7f},
        '{W, 8'h60, 8'h11, 8'h00}, '{W, 8'h04, 8'h03, 8'h00}, '{W, 8'h03, 8'h41, 8'h00},
        '{W, 8'h01, 8'h46, 8'h00}, '{W, 8'h00, 8'h5d, 8'h00}, '{R, 8'h46, 8'h00, 8'h5d}
    };

    dmtr_top dut_u (.clock(clock), .rst(rst), .req(req), .tbl(tbl),
        .program_counter_upper_bits(pc_up), .pc_low(pc_low), .pm_data(pm_data),
        .rdata(rdata), .busy(busy), .tbl_done(tbl_done), .pcl_load(pcl_load),
        .pcl_value(pcl_value), .pm_addr(pm_addr), .pm_rd(pm_rd));
    dmtr_pm_model pm_u (.clock(clock), .pm_addr(pm_addr), .pm_rd(pm_rd), .pm_data(pm_data));

    initial
    begin
        clock = 1'b0;
        forever #50 clock = ~clock;
    end

    // ======================================================
    // checking and drivers
    task automatic chk(string name, logic [15:0] seen, logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // called at a falling edge; leaves req up so rows run back to back
    task automatic do_op(dmtr_row_s r);
        dmtr_req_s q;
        q = '0;
        q.addr = r.addr;
        q.wdata = r.wdata;
        q.bit_sel = r.wdata[2:0];
        q.wr = (r.op == W);
        q.rd = (r.op == R);
        q.bit_set = (r.op == S);
        q.bit_clr = (r.op == C);
        req = q;
        @(negedge clock);
        if (r.op == R) chk("rdata", {8'h00, rdata}, {8'h00, r.exp});
    endtask

    task automatic tread(logic last, logic [7:0] dest, logic [7:0] idx);
        logic [13:0] a;
        a = last ? {LAST_PAGE_UPPER, idx} : {pc_up, idx};
        do_op('{W, ADDR_TABLE_INDEX, idx, 8'h00});
        req = '0;
        tbl = '{1'b1, last, dest};
        @(negedge clock);
        chk("pm_addr", {2'b00, pm_addr}, {2'b00, a});
        chk("busy", {13'h0, busy, pm_rd, tbl_done}, 16'h0007);
        chk("pcl_load", {15'h0, pcl_load}, 16'h0000);
        // go held and a write issued while busy: both must be ignored
        req = '{1'b0, 1'b1, 1'b0, 1'b0, 3'h0, 8'h60, 8'hee};
        @(negedge clock);
        tbl = '0;
        req = '0;
        chk("busy_end", {15'h0, busy}, 16'h0000);
        do_op('{R, dest, 8'h00, a[7:0] ^ 8'ha5});
        do_op('{R, ADDR_TABLE_UPPER_BYTE, 8'h00, a[13:6]});
        do_op('{W, ADDR_TABLE_UPPER_BYTE, 8'hab, 8'h00});
        do_op('{R, ADDR_TABLE_UPPER_BYTE, 8'h00, a[13:6]});
        do_op('{R, 8'h60, 8'h00, 8'h11});
        $display("table read done at %h", a);
    endtask

    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    // ======================================================
    // sequence
    initial
    begin
        rst = 1'b1;
        req = '0;
        tbl = '0;
        pc_up = 6'h2a;
        pc_low = 8'h9c;
        repeat (20) @(negedge clock);
        chk("reset_outs", {pm_addr, busy, pm_rd}, 16'h0000);
        rst = 1'b0;
        foreach (rows[i]) do_op(rows[i]);
        $display("register table done");
        // a counter low write is handed on as a one-cycle load pulse
        do_op('{W, ADDR_PROGRAM_COUNTER_LOW, 8'h5a, 8'h00});
        chk("pcl_load", {7'h00, pcl_load, pcl_value}, 16'h015a);
        req = '0;
        @(negedge clock);
        chk("pcl_pulse", {15'h0, pcl_load}, 16'h0000);
        $display("counter low write done");
        // one table read at a time, each with one cpu write issued while it is busy
        tread(1'b1, 8'h50, 8'h06);
        pc_up = 6'h15;
        tread(1'b0, 8'h02, 8'h10);
        req = '0;
        rst = 1'b1;
        repeat (2) @(negedge clock);
        rst = 1'b0;
        do_op('{R, ADDR_BANK_SELECT, 8'h00, 8'h00});
        do_op('{R, ADDR_TABLE_UPPER_BYTE, 8'h00, 8'h00});
        $display("second reset done");
        end_sim();
    end

    initial
    begin
        #(3000 * 100);
        mismatches++;
        end_sim();
    end
endmodule
`default_nettype wire
